/* logic/twt_target.sv */
// Target end: filtered framing, receive/send words, write-cycle lockout
`timescale 1ns/1ps
`default_nettype none
`include "twt_consts.svh"

// Functional notes
// - Data changes only while clock low
// - Data edge with clock high is framing
// - Falling data, clock high starts frame
// - Rising data, clock high stops anywhere
// - Stop after read returns to standby
// - Every transfer is eight-bit words
// - Target pulls data low on ninth clock
// - Standby at reset and after stop, once any internal write ends
// - Controller recovers: up to nine pulses, then start
// - Internal write ends within five milliseconds
// - Controller clock rate capped at 400 kHz
// - Short input glitches are rejected
// - Target only pulls low or releases
// - Bus ignored, no acknowledge during write
module twt_target #(
    parameter int FILT_CYC = `TWT_GLITCH_CYC,
    parameter int WR_CYC = `TWT_WR_CYC
) (
    input wire logic clk,
    input wire logic rst,
    twt_if.target bus,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic frame_start,
    output logic frame_stop,
    output logic standby,
    output logic busy
);
    // ------------------------------------------------------------
    // Input synchronisers and glitch filters
    // ------------------------------------------------------------
    logic [1:0] line_in;
    wire logic [1:0] filt;
    assign line_in = {bus.scl, bus.sda};

    genvar g;
    for (g = 0; g < 2; g++) begin : g_line
        logic [1:0] sy;
        logic [1:0] next_sy;
        logic flt;
        logic next_flt;
        logic [7:0] cnt;
        logic [7:0] next_cnt;

        // Two-stage sync, then accept a level only once it has held
        always_comb begin
            next_sy = {sy[0], line_in[g]};
            next_flt = flt;
            next_cnt = 8'h00;
            if (sy[1] != flt) begin
                if (cnt == 8'(FILT_CYC))
                    next_flt = sy[1];
                else
                    next_cnt = cnt + 8'h01;
            end
        end

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                sy <= {2{`TWT_IDLE_LEVEL}};
                flt <= `TWT_IDLE_LEVEL;
                cnt <= 8'h00;
            end else begin
                sy <= next_sy;
                flt <= next_flt;
                cnt <= next_cnt;
            end
        end
        assign filt[g] = flt;
    end

    // ------------------------------------------------------------
    // Edge and condition detection
    // ------------------------------------------------------------
    logic scl_q;
    logic sda_q;
    logic scl_f;
    logic sda_f;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    assign scl_f = filt[1];
    assign sda_f = filt[0];
    assign scl_rise = scl_f & ~scl_q;
    assign scl_fall = ~scl_f & scl_q;
    // Data moving while clock stays high is framing, never a bit
    assign start_ev = scl_q & scl_f & sda_q & ~sda_f;
    assign stop_ev = scl_q & scl_f & ~sda_q & sda_f;

    // ------------------------------------------------------------
    // Framing state machine and two-entry receive buffer
    // ------------------------------------------------------------
    twt_pkg::twt_tgt_state_e state, next_state;
    logic [3:0] bits, next_bits;
    logic [7:0] shreg, next_shreg;
    logic first, next_first;
    logic dir_rd, next_dir_rd;
    logic wrote, next_wrote;
    logic oe_n, next_oe_n;
    logic [7:0] sk_d, next_sk_d;
    logic sk_v, next_sk_v;
    logic [7:0] next_rx_data;
    logic next_rx_valid;
    logic next_tx_ready;
    logic next_frame_start;
    logic next_frame_stop;
    logic next_standby;
    logic next_busy;
    logic [`TWT_WR_CNT_W-1:0] wr_cnt, next_wr_cnt;

    // Next values for the whole frame engine
    always_comb begin
        next_state = state;
        next_bits = bits;
        next_shreg = shreg;
        next_first = first;
        next_dir_rd = dir_rd;
        next_wrote = wrote;
        next_oe_n = oe_n;
        next_sk_d = sk_d;
        next_sk_v = sk_v;
        next_rx_data = rx_data;
        next_rx_valid = rx_valid;
        next_tx_ready = 1'b0;
        next_frame_start = 1'b0;
        next_frame_stop = 1'b0;
        next_busy = busy;
        next_wr_cnt = wr_cnt;
        // Drain side: skid entry moves up when head is taken
        if (rx_valid && rx_ready) begin
            next_rx_valid = sk_v;
            next_rx_data = sk_d;
            next_sk_v = 1'b0;
        end
        if (busy) begin
            // Internal write: bus is deaf, line released
            next_oe_n = 1'b1;
            next_state = twt_pkg::TGT_IDLE;
            if (wr_cnt == `TWT_WR_CNT_W'(WR_CYC - 1)) begin
                next_busy = 1'b0;
                next_wr_cnt = '0;
            end else begin
                next_wr_cnt = wr_cnt + `TWT_WR_CNT_W'(1);
            end
        end else if (stop_ev) begin
            next_state = twt_pkg::TGT_IDLE;
            next_oe_n = 1'b1;
            next_frame_stop = 1'b1;
            next_busy = wrote;
            next_wrote = 1'b0;
        end else if (start_ev) begin
            next_state = twt_pkg::TGT_RX;
            next_bits = 4'h0;
            next_first = 1'b1;
            next_oe_n = 1'b1;
            next_frame_start = 1'b1;
        end else begin
            case (state)
                twt_pkg::TGT_IDLE: begin
                    next_oe_n = 1'b1;
                end
                twt_pkg::TGT_RX: begin
                    if (scl_rise) begin
                        // Sample only on the clock's rising edge
                        next_shreg = {shreg[6:0], sda_f};
                        next_bits = bits + 4'h1;
                    end else if (scl_fall && bits == `TWT_WORD_BITS) begin
                        if (!sk_v) begin
                            next_oe_n = 1'b0;
                            next_state = twt_pkg::TGT_ACK;
                            if (next_rx_valid) begin
                                next_sk_d = shreg;
                                next_sk_v = 1'b1;
                            end else begin
                                next_rx_data = shreg;
                                next_rx_valid = 1'b1;
                            end
                            next_first = 1'b0;
                            if (first)
                                next_dir_rd = shreg[0];
                            else if (!dir_rd)
                                next_wrote = 1'b1;
                        end else begin
                            // Buffer full: withhold acknowledge
                            next_state = twt_pkg::TGT_WAIT;
                        end
                    end
                end
                twt_pkg::TGT_ACK: begin
                    if (scl_fall) begin
                        next_bits = 4'h0;
                        next_oe_n = 1'b1;
                        next_state = twt_pkg::TGT_RX;
                        if (dir_rd) begin
                            next_shreg = tx_valid ? tx_data : 8'hFF;
                            next_tx_ready = tx_valid;
                            // First bit set up while clock is low
                            next_oe_n = next_shreg[7];
                            next_bits = 4'h1;
                            next_state = twt_pkg::TGT_TX;
                        end
                    end
                end
                twt_pkg::TGT_TX: begin
                    if (scl_fall) begin
                        if (bits == `TWT_WORD_BITS) begin
                            next_oe_n = 1'b1;
                            next_state = twt_pkg::TGT_TACK;
                        end else begin
                            next_oe_n = shreg[6];
                            next_shreg = {shreg[6:0], 1'b1};
                            next_bits = bits + 4'h1;
                        end
                    end
                end
                twt_pkg::TGT_TACK: begin
                    if (scl_rise)
                        next_state = sda_f ? twt_pkg::TGT_WAIT
                                           : twt_pkg::TGT_ACK;
                end
                twt_pkg::TGT_WAIT: begin
                    next_oe_n = 1'b1;
                end
                default: begin
                    next_state = twt_pkg::TGT_IDLE;
                    next_oe_n = 1'b1;
                end
            endcase
        end
        next_standby = (next_state == twt_pkg::TGT_IDLE) && !next_busy;
    end

    // Register the frame engine
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_q <= `TWT_IDLE_LEVEL;
            sda_q <= `TWT_IDLE_LEVEL;
            state <= twt_pkg::TGT_IDLE;
            bits <= 4'h0;
            shreg <= 8'h00;
            first <= 1'b0;
            dir_rd <= 1'b0;
            wrote <= 1'b0;
            oe_n <= 1'b1;
            sk_d <= 8'h00;
            sk_v <= 1'b0;
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
            tx_ready <= 1'b0;
            frame_start <= 1'b0;
            frame_stop <= 1'b0;
            standby <= 1'b1;
            busy <= 1'b0;
            wr_cnt <= '0;
        end else begin
            scl_q <= scl_f;
            sda_q <= sda_f;
            state <= next_state;
            bits <= next_bits;
            shreg <= next_shreg;
            first <= next_first;
            dir_rd <= next_dir_rd;
            wrote <= next_wrote;
            oe_n <= next_oe_n;
            sk_d <= next_sk_d;
            sk_v <= next_sk_v;
            rx_data <= next_rx_data;
            rx_valid <= next_rx_valid;
            tx_ready <= next_tx_ready;
            frame_start <= next_frame_start;
            frame_stop <= next_frame_stop;
            standby <= next_standby;
            busy <= next_busy;
            wr_cnt <= next_wr_cnt;
        end
    end

    // Open-drain: output level fixed low, only the enable moves
    assign bus.tgt_sda_o = 1'b0;
    assign bus.tgt_sda_oe_n = oe_n;
endmodule // twt_target
`default_nettype wire

/* logic/twt_consts.svh */
// Timing counts, widths and reset levels of the two-wire framing ends
`ifndef TWT_CONSTS_SVH
`define TWT_CONSTS_SVH

`define TWT_CLK_MHZ 125
`define TWT_WORD_BITS 4'h8
`define TWT_RECOVER_PULSES 4'h9
`define TWT_IDLE_LEVEL 1'b1
`define TWT_GLITCH_NS 50
`define TWT_GLITCH_CYC ((`TWT_GLITCH_NS * `TWT_CLK_MHZ + 999) / 1000)
`define TWT_WR_MS 5
`define TWT_WR_CYC (`TWT_WR_MS * 1000 * `TWT_CLK_MHZ)
`define TWT_WR_CNT_W 20
`define TWT_SCL_KHZ 400
`define TWT_QTR_CYC ((`TWT_CLK_MHZ * 1000 + 4 * `TWT_SCL_KHZ - 1) / (4 * `TWT_SCL_KHZ))
`define TWT_DIV_W 16

`endif

/* logic/twt_pkg.sv */
// Types shared by the two-wire framing ends
package twt_pkg;
    typedef enum logic [5:0] {
        TGT_IDLE = 6'h01,
        TGT_RX   = 6'h02,
        TGT_ACK  = 6'h04,
        TGT_TX   = 6'h08,
        TGT_TACK = 6'h10,
        TGT_WAIT = 6'h20
    } twt_tgt_state_e;

    typedef enum logic [5:0] {
        CTL_IDLE  = 6'h01,
        CTL_START = 6'h02,
        CTL_BIT   = 6'h04,
        CTL_RECOV = 6'h08,
        CTL_STOP  = 6'h10,
        CTL_DONE  = 6'h20
    } twt_ctl_state_e;

    typedef enum logic [2:0] {
        OP_START   = 3'h0,
        OP_WRITE   = 3'h1,
        OP_READ    = 3'h2,
        OP_STOP    = 3'h3,
        OP_RECOVER = 3'h4
    } twt_op_e;
endpackage

/* logic/twt_if.sv */
// Two-wire bus: clock from the controller, wired-AND data line
`timescale 1ns/1ps
`default_nettype none
interface twt_if;
    logic scl;
    logic ctl_sda_o;
    logic ctl_sda_oe_n;
    logic tgt_sda_o;
    logic tgt_sda_oe_n;
    logic sda;

    // Pulled high unless some driver is enabled and low
    assign sda = ~((~ctl_sda_oe_n & ~ctl_sda_o) | (~tgt_sda_oe_n & ~tgt_sda_o));

    modport ctrl (output scl, output ctl_sda_o, output ctl_sda_oe_n,
                  input sda);
    modport target (input scl, input sda,
                    output tgt_sda_o, output tgt_sda_oe_n);
endinterface
`default_nettype wire

/* logic/twt_ctrl.sv */
// Controller end: clock divider, start/stop, words, bus recovery
`timescale 1ns/1ps
`default_nettype none
`include "twt_consts.svh"

module twt_ctrl #(
    parameter int QTR_CYC = `TWT_QTR_CYC
) (
    input wire logic clk,
    input wire logic rst,
    twt_if.ctrl bus,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_op,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_ack,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_ack
);
    // ------------------------------------------------------------
    // Quarter-bit divider, data sync and sequencer
    // ------------------------------------------------------------
    twt_pkg::twt_ctl_state_e state, next_state;
    logic [`TWT_DIV_W-1:0] div, next_div;
    logic [1:0] qtr, next_qtr;
    logic [3:0] bits, next_bits;
    logic [8:0] tx, next_tx;
    logic [8:0] rx, next_rx;
    logic [1:0] sy, next_sy;
    logic scl, next_scl;
    logic oe_n, next_oe_n;
    logic next_cmd_ready;
    logic next_rsp_valid;
    logic [7:0] next_rsp_data;
    logic next_rsp_ack;
    logic tick;

    // One-cycle enable each quarter of a bit; period bounds clock rate
    assign tick = (div == `TWT_DIV_W'(QTR_CYC - 1));

    // Next values for the sequencer
    always_comb begin
        next_state = state;
        next_div = tick ? '0 : div + `TWT_DIV_W'(1);
        next_qtr = qtr;
        next_bits = bits;
        next_tx = tx;
        next_rx = rx;
        next_sy = {sy[0], bus.sda};
        next_scl = scl;
        next_oe_n = oe_n;
        next_cmd_ready = cmd_ready;
        next_rsp_valid = 1'b0;
        next_rsp_data = rsp_data;
        next_rsp_ack = rsp_ack;
        if (tick)
            next_qtr = qtr + 2'h1;
        case (state)
            twt_pkg::CTL_IDLE: begin
                if (cmd_valid && cmd_ready) begin
                    next_cmd_ready = 1'b0;
                    next_div = '0;
                    next_qtr = 2'h0;
                    next_bits = 4'h0;
                    case (cmd_op)
                        twt_pkg::OP_START: next_state = twt_pkg::CTL_START;
                        twt_pkg::OP_WRITE: begin
                            next_tx = {cmd_data, 1'b1};
                            next_state = twt_pkg::CTL_BIT;
                        end
                        twt_pkg::OP_READ: begin
                            next_tx = {8'hFF, ~cmd_ack};
                            next_state = twt_pkg::CTL_BIT;
                        end
                        twt_pkg::OP_STOP: next_state = twt_pkg::CTL_STOP;
                        twt_pkg::OP_RECOVER: begin
                            next_tx = 9'h1FF;
                            next_state = twt_pkg::CTL_RECOV;
                        end
                        default: next_state = twt_pkg::CTL_DONE;
                    endcase
                end
            end
            twt_pkg::CTL_START: begin
                if (tick) begin
                    case (qtr)
                        2'h0: next_oe_n = 1'b1;
                        2'h1: next_scl = 1'b1;
                        2'h2: next_oe_n = 1'b0;
                        default: begin
                            next_scl = 1'b0;
                            next_state = twt_pkg::CTL_DONE;
                        end
                    endcase
                end
            end
            twt_pkg::CTL_BIT, twt_pkg::CTL_RECOV: begin
                if (tick) begin
                    case (qtr)
                        2'h0: next_oe_n = tx[8];
                        2'h1: next_scl = 1'b1;
                        2'h2: next_rx = {rx[7:0], sy[1]};
                        default: begin
                            next_scl = 1'b0;
                            next_tx = {tx[7:0], 1'b1};
                            next_bits = bits + 4'h1;
                            if (state == twt_pkg::CTL_RECOV) begin
                                // Stop pulsing once data seen high
                                if (rx[0] || next_bits == `TWT_RECOVER_PULSES)
                                    next_state = twt_pkg::CTL_START;
                            end else if (bits == `TWT_WORD_BITS) begin
                                next_state = twt_pkg::CTL_DONE;
                            end
                        end
                    endcase
                end
            end
            twt_pkg::CTL_STOP: begin
                if (tick) begin
                    case (qtr)
                        2'h0: next_oe_n = 1'b0;
                        2'h1: next_scl = 1'b1;
                        2'h2: next_oe_n = 1'b1;
                        default: next_state = twt_pkg::CTL_DONE;
                    endcase
                end
            end
            twt_pkg::CTL_DONE: begin
                next_rsp_valid = 1'b1;
                next_rsp_data = rx[8:1];
                next_rsp_ack = ~rx[0];
                next_cmd_ready = 1'b1;
                next_state = twt_pkg::CTL_IDLE;
            end
            default: begin
                next_state = twt_pkg::CTL_IDLE;
                next_cmd_ready = 1'b1;
            end
        endcase
    end

    // Register the sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= twt_pkg::CTL_IDLE;
            div <= '0;
            qtr <= 2'h0;
            bits <= 4'h0;
            tx <= 9'h1FF;
            rx <= 9'h000;
            sy <= {2{`TWT_IDLE_LEVEL}};
            scl <= `TWT_IDLE_LEVEL;
            oe_n <= 1'b1;
            cmd_ready <= 1'b1;
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
            rsp_ack <= 1'b0;
        end else begin
            state <= next_state;
            div <= next_div;
            qtr <= next_qtr;
            bits <= next_bits;
            tx <= next_tx;
            rx <= next_rx;
            sy <= next_sy;
            scl <= next_scl;
            oe_n <= next_oe_n;
            cmd_ready <= next_cmd_ready;
            rsp_valid <= next_rsp_valid;
            rsp_data <= next_rsp_data;
            rsp_ack <= next_rsp_ack;
        end
    end

    assign bus.scl = scl;
    assign bus.ctl_sda_o = 1'b0;
    assign bus.ctl_sda_oe_n = oe_n;
endmodule // twt_ctrl
`default_nettype wire

/* tb/twt_bus_monitor.sv */
// Assertions on the shared two-wire bus between controller and target
`timescale 1ns/1ps
`default_nettype none
module twt_bus_monitor #(
    parameter int QTR_CYC = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic tgt_sda_o,
    input wire logic tgt_sda_oe_n
);
    // ------------------------------------------------------------
    // Helper state: level run length, bit index, frame direction
    // ------------------------------------------------------------
    logic scl_q;
    logic sda_q;
    logic [7:0] run_len;
    logic [3:0] bit_n;
    logic first_word;
    logic rd_frame;

    // Track clock level runs and word position from raw lines
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            run_len <= 8'h00;
            bit_n <= 4'h0;
            first_word <= 1'b0;
            rd_frame <= 1'b0;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (scl != scl_q)
                run_len <= 8'h01;
            else if (run_len != 8'hFF)
                run_len <= run_len + 8'h01;
            if (scl && scl_q && sda_q && !sda) begin
                bit_n <= 4'h0;
                first_word <= 1'b1;
            end else if (scl && !scl_q) begin
                bit_n <= (bit_n == 4'h8) ? 4'h0 : bit_n + 4'h1;
                if (bit_n == 4'h8)
                    first_word <= 1'b0;
                if (first_word && bit_n == 4'h7)
                    rd_frame <= sda;
            end
        end
    end

    // ------------------------------------------------------------
    // Bus properties
    // ------------------------------------------------------------
    default clocking mon_cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence start_seen;
        scl && $fell(sda);
    endsequence
    sequence stop_seen;
        scl && $rose(sda);
    endsequence

    pull_low_only_a: assert property (
        tgt_sda_oe_n || (!tgt_sda_o && !sda))
        else $error("target drives data line high");
    change_clk_low_a: assert property (
        $changed(tgt_sda_oe_n) |-> !scl)
        else $error("target data changed with clock high");
    start_hold_a: assert property (
        start_seen |-> scl [*8])
        else $error("clock not held high after start");
    stop_free_a: assert property (
        stop_seen |-> sda [*8])
        else $error("data line not free after stop");
    high_width_a: assert property (
        $fell(scl) |-> run_len >= QTR_CYC)
        else $error("clock high phase too short");
    low_width_a: assert property (
        $rose(scl) |-> run_len >= QTR_CYC)
        else $error("clock low phase too short");
    idle_after_reset_a: assert property (
        $fell(rst) |-> (scl && sda && tgt_sda_oe_n) [*3])
        else $error("bus not idle after reset");
    ninth_ack_a: assert property (
        $rose(scl) && !tgt_sda_oe_n && !rd_frame |-> bit_n == 4'h8)
        else $error("target pulled data low outside ninth clock");
endmodule // twt_bus_monitor
`default_nettype wire

/* tb/two_wire_target_bus_framing_bench.sv */
// Bench: controller and target ends joined on one two-wire bus
`timescale 1ns/1ps
`default_nettype none
module two_wire_target_bus_framing_bench;
    // ------------------------------------------------------------
    // Signals, ends and bus checker
    // ------------------------------------------------------------
    localparam int QTR = 16;
    localparam int WRC = 1000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic [2:0] cmd_op = 3'h0;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_ack = 1'b0;
    logic rx_ready = 1'b1;
    logic [7:0] tx_data = 8'h3C;
    logic tx_valid = 1'b1;
    logic cmd_ready, rsp_valid, rsp_ack, rx_valid, tx_ready;
    logic frame_start, frame_stop, standby, busy, ackd;
    logic [7:0] rsp_data, rx_data, got;
    logic [7:0] rx_q[$];
    int err_total = 0;
    int n_tests = 0;
    int cycles = 0;
    int n_start = 0;
    int n_stop = 0;
    twt_if bus_if ();

    twt_ctrl #(.QTR_CYC(QTR)) twt_ctrl_inst (.clk(clk), .rst(rst),
        .bus(bus_if.ctrl), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_data(cmd_data), .cmd_ack(cmd_ack), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));
    twt_target #(.FILT_CYC(1), .WR_CYC(WRC)) twt_target_inst (.clk(clk),
        .rst(rst), .bus(bus_if.target), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready),
        .frame_start(frame_start), .frame_stop(frame_stop),
        .standby(standby), .busy(busy));
    twt_bus_monitor #(.QTR_CYC(QTR)) twt_bus_monitor_inst (.clk(clk),
        .rst(rst), .scl(bus_if.scl), .sda(bus_if.sda),
        .tgt_sda_o(bus_if.tgt_sda_o), .tgt_sda_oe_n(bus_if.tgt_sda_oe_n));

    // 125 MHz clock
    always #4 clk = ~clk;

    // Count frame pulses, collect words, swap read data, cut hangs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (frame_start === 1'b1)
            n_start <= n_start + 1;
        if (frame_stop === 1'b1)
            n_stop <= n_stop + 1;
        if (rx_valid === 1'b1 && rx_ready === 1'b1)
            rx_q.push_back(rx_data);
        if (tx_ready === 1'b1)
            tx_data <= ~tx_data;
        if (cycles == 40000) begin
            err_total = err_total + 1;
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Issue one command, hold it until taken, wait for its answer
    task automatic cmd(input logic [2:0] op, input logic [7:0] d,
                       input logic a);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_data <= d;
        cmd_ack <= a;
        @(posedge clk);
        while (cmd_ready !== 1'b1)
            @(posedge clk);
        cmd_valid <= 1'b0;
        do @(posedge clk); while (rsp_valid !== 1'b1);
        got = rsp_data;
        ackd = rsp_ack;
    endtask

    // Wait out the internal write cycle
    task automatic wait_free();
        int n;
        n = 0;
        while (busy !== 1'b0) begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        chk({7'h00, n <= WRC}, 8'h01);
        chk({6'h00, standby, busy}, 8'h02);
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({6'h00, standby, busy}, 8'h02);
        chk({7'h00, bus_if.sda}, 8'h01);
        $display("reset test done");
        cmd(twt_pkg::OP_START, 8'h00, 1'b0);
        chk(n_start[7:0], 8'h01);
        cmd(twt_pkg::OP_WRITE, 8'hA0, 1'b0);
        chk({7'h00, ackd}, 8'h01);
        cmd(twt_pkg::OP_WRITE, 8'h5A, 1'b0);
        chk({7'h00, ackd}, 8'h01);
        cmd(twt_pkg::OP_STOP, 8'h00, 1'b0);
        chk(n_stop[7:0], 8'h01);
        chk({6'h00, standby, busy}, 8'h01);
        cmd(twt_pkg::OP_START, 8'h00, 1'b0);
        cmd(twt_pkg::OP_WRITE, 8'hA0, 1'b0);
        chk({7'h00, ackd}, 8'h00);
        cmd(twt_pkg::OP_STOP, 8'h00, 1'b0);
        chk({n_start[3:0], n_stop[3:0]}, 8'h11);
        chk(rx_q.pop_front(), 8'hA0);
        chk(rx_q.pop_front(), 8'h5A);
        wait_free();
        $display("write test done");
        cmd(twt_pkg::OP_START, 8'h00, 1'b0);
        cmd(twt_pkg::OP_WRITE, 8'hA1, 1'b0);
        chk({7'h00, ackd}, 8'h01);
        cmd(twt_pkg::OP_READ, 8'h00, 1'b1);
        chk(got, 8'h3C);
        cmd(twt_pkg::OP_READ, 8'h00, 1'b0);
        chk(got, 8'hC3);
        cmd(twt_pkg::OP_STOP, 8'h00, 1'b0);
        @(posedge clk);
        chk({6'h00, standby, busy}, 8'h02);
        chk(rx_q.pop_front(), 8'hA1);
        $display("read test done");
        rx_ready <= 1'b0;
        cmd(twt_pkg::OP_START, 8'h00, 1'b0);
        cmd(twt_pkg::OP_WRITE, 8'h10, 1'b0);
        cmd(twt_pkg::OP_WRITE, 8'h20, 1'b0);
        chk({7'h00, ackd}, 8'h01);
        cmd(twt_pkg::OP_WRITE, 8'h30, 1'b0);
        chk({7'h00, ackd}, 8'h00);
        cmd(twt_pkg::OP_STOP, 8'h00, 1'b0);
        rx_ready <= 1'b1;
        wait_free();
        chk(rx_q.pop_front(), 8'h10);
        chk(rx_q.pop_front(), 8'h20);
        chk(rx_q.size() == 0 ? 8'h00 : 8'hFF, 8'h00);
        $display("buffer test done");
        cmd(twt_pkg::OP_RECOVER, 8'h00, 1'b0);
        chk(n_start[7:0], 8'h04);
        // Nothing offered to send: the target fills with ones
        tx_valid <= 1'b0;
        cmd(twt_pkg::OP_WRITE, 8'hA1, 1'b0);
        cmd(twt_pkg::OP_READ, 8'h00, 1'b0);
        chk(got, 8'hFF);
        chk(tx_data, 8'h3C);
        cmd(twt_pkg::OP_STOP, 8'h00, 1'b0);
        chk(n_stop[7:0], 8'h04);
        $display("recovery test done");
        end_of_test();
    end
endmodule // two_wire_target_bus_framing_bench
`default_nettype wire
